// >>> logic/watchdog_interval_timer_ch0.sv
// Operation
// - 8-bit counter, software readable and writable
// - enable high: count on selected tick
// - enable low: counter halted at zero
// - wrap FF to 00 sets overflow flag
// - internal reset clears overflow flag
// - zero clears flag only after read-while-set
// - writing enable zero clears overflow flag
// - writes of one to flag ignored
// - mode bit: 0 interval, 1 watchdog
// - watchdog overflow: action 0 nmi, 1 reset
// - codes 000,010,111 select /2,/128,/131072
// - codes 011,100 select /512,/2048
// - interval mode overflow raises interval interrupt
`timescale 1ns/1ns
module watchdog_interval_timer_ch0
  import wdt_pkg::*;
#(
  parameter int DIV_001_P = DIV_001,
  parameter int DIV_101_P = DIV_101,
  parameter int DIV_110_P = DIV_110
) (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [3:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output      logic [31:0] readdata,
  output      logic        waitrequest,
  output      logic        interval_overflow_interrupt,
  output      logic        nmi_request,
  output      logic        internal_reset_request,
  output      logic        irq
);

  // ************************************************************
  // state
  // ************************************************************
  bus_state_e       bus_r;        // answer state
  logic [7:0]       count_r;      // watchdog_count
  logic             ovf_r;        // overflow_flag
  logic             mode_r;       // timer_mode_select
  logic             en_r;         // timer_enable_bit
  logic             act_r;        // overflow action select
  logic [2:0]       cks_r;        // clock_select_bit2..0
  logic             armed_r;      // flag seen set by a read
  logic [PRE_W-1:0] pre_r;        // system_clock_prescaler
  logic [2:0]       ev_r;         // sticky event status
  logic [2:0]       msk_r;        // event mask
  logic [31:0]      rdata_r;      // registered read data

  // ************************************************************
  // bus decode
  // ************************************************************
  logic       acc;        // access taken this cycle
  logic       wr_en;      // write accepted
  logic       rd_en;      // read accepted
  logic       wr_count;   // write to counter low byte
  logic       wr_ctrl;    // write to control low byte
  logic       wr_st;      // write to event status
  logic       wr_msk;     // write to mask
  logic       tick;       // selected prescaler tick
  logic       wrap;       // counter wraps this cycle
  logic [7:0] ctrl_view;  // control register image

  // one wait cycle on every access, answer in the second
  assign acc         = (read | write) & (bus_r == BUS_IDLE);
  assign waitrequest = (read | write) & (bus_r != BUS_ACK);
  assign wr_en       = write & (bus_r == BUS_ACK);
  assign rd_en       = read & (bus_r == BUS_ACK);
  assign wr_count    = wr_en & (address == ADDR_COUNT) & byteenable[0];
  assign wr_ctrl     = wr_en & (address == ADDR_CTRL) & byteenable[0];
  assign wr_st       = wr_en & (address == ADDR_IRQ_ST) & byteenable[0];
  assign wr_msk      = wr_en & (address == ADDR_IRQ_MSK) & byteenable[0];

  // bus answer sequencer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_r <= BUS_IDLE;
    end else begin
      case (bus_r)
        BUS_IDLE: begin
          if (acc) begin
            bus_r <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          bus_r <= BUS_IDLE;  // request released after answer
        end
        default: begin
          bus_r <= BUS_IDLE;
        end
      endcase
    end
  end

  // reserved bit always reads zero
  assign ctrl_view = {ovf_r, mode_r, en_r, 1'b0, act_r, cks_r};

  // ************************************************************
  // prescaler and tick select
  // ************************************************************
  // free running; a clock-select change may give one short period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // tick when the low bits of the prescaler roll over
  function automatic logic roll(input logic [PRE_W-1:0] p, input int div);
    logic [PRE_W-1:0] m;
    m = PRE_W'(div - 1);
    return (p & m) == m;
  endfunction : roll

  always_comb begin
    tick = 1'b0;
    case (cks_r)
      3'h0:    tick = roll(pre_r, DIV_000);
      3'h1:    tick = roll(pre_r, DIV_001_P);
      3'h2:    tick = roll(pre_r, DIV_010);
      3'h3:    tick = roll(pre_r, DIV_011);
      3'h4:    tick = roll(pre_r, DIV_100);
      3'h5:    tick = roll(pre_r, DIV_101_P);
      3'h6:    tick = roll(pre_r, DIV_110_P);
      3'h7:    tick = roll(pre_r, DIV_111);
      default: tick = 1'b0;
    endcase
  end

  // counter wraps only on an enabled tick at max, not during a counter write
  assign wrap = en_r & tick & (count_r == COUNT_MAX) & ~wr_count;

  // ************************************************************
  // counter
  // ************************************************************
  // software write beats a coincident count-up
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_r <= COUNT_RESET;
    end else if (!en_r || (wr_ctrl && !writedata[EN_BIT])) begin
      count_r <= COUNT_RESET;
    end else if (wr_count) begin
      count_r <= writedata[7:0];
    end else if (tick) begin
      count_r <= count_r + 8'h01;
    end
  end

  // ************************************************************
  // control/status fields
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_r <= CTRL_RESET[MODE_BIT];
      en_r   <= CTRL_RESET[EN_BIT];
      act_r  <= CTRL_RESET[ACT_BIT];
      cks_r  <= CTRL_RESET[2:0];
    end else if (wr_ctrl) begin
      mode_r <= writedata[MODE_BIT];
      en_r   <= writedata[EN_BIT];
      act_r  <= writedata[ACT_BIT];
      cks_r  <= writedata[2:0];
    end
  end

  // read of control while flag set arms the clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_r <= 1'b0;
    end else if (!ovf_r) begin
      armed_r <= 1'b0;
    end else if (rd_en && address == ADDR_CTRL) begin
      armed_r <= 1'b1;
    end
  end

  // overflow flag: a new wrap wins over any clear
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ovf_r <= 1'b0;
    end else if (wrap && !(mode_r && act_r)) begin
      ovf_r <= 1'b1;
    end else if (wrap) begin
      ovf_r <= 1'b0;  // internal reset clears it
    end else if (wr_ctrl && !writedata[EN_BIT]) begin
      ovf_r <= 1'b0;
    end else if (wr_ctrl && armed_r && !writedata[OVF_BIT]) begin
      ovf_r <= 1'b0;  // one written here is ignored
    end
  end

  // ************************************************************
  // overflow actions
  // ************************************************************
  // one-cycle request pulses, registered
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      interval_overflow_interrupt <= 1'b0;
      nmi_request                 <= 1'b0;
      internal_reset_request      <= 1'b0;
    end else begin
      interval_overflow_interrupt <= wrap & ~mode_r;
      nmi_request                 <= wrap & mode_r & ~act_r;
      internal_reset_request      <= wrap & mode_r & act_r;
    end
  end

  // ************************************************************
  // interrupt status and mask
  // ************************************************************
  logic [2:0] ev_set;  // events this cycle
  assign ev_set = {wrap & mode_r & act_r, wrap & mode_r & ~act_r, wrap & ~mode_r};

  // write one to clear; a same-cycle event stays set
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_r <= 3'h0;
    end else if (wr_st) begin
      ev_r <= (ev_r & ~writedata[2:0]) | ev_set;
    end else begin
      ev_r <= ev_r | ev_set;
    end
  end

  // mask register, one enables the event
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      msk_r <= 3'h0;
    end else if (wr_msk) begin
      msk_r <= writedata[2:0];
    end
  end

  assign irq = |(ev_r & msk_r);

  // ************************************************************
  // read data
  // ************************************************************
  // captured at the first access cycle, stands at the answer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_r <= 32'h0;
    end else if (acc && read) begin
      case (address)
        ADDR_COUNT:   rdata_r <= {24'h0, count_r};
        ADDR_CTRL:    rdata_r <= {24'h0, ctrl_view};
        ADDR_IRQ_ST:  rdata_r <= {29'h0, ev_r};
        ADDR_IRQ_MSK: rdata_r <= {29'h0, msk_r};
        default:      rdata_r <= 32'h0;  // unmapped reads zero
      endcase
    end
  end

  assign readdata = rdata_r;

  // ************************************************************
  // checks
  // ************************************************************
  property p_halt;
    @(posedge clk) disable iff (!rst_b) !en_r |=> count_r == 8'h00;
  endproperty
  a_halt: assert property (p_halt) else $error("counter not held at zero");

  property p_wrap_flag;
    @(posedge clk) disable iff (!rst_b)
      (wrap && !(mode_r && act_r)) |=> ovf_r && count_r == 8'h00;
  endproperty
  a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");

  property p_rst_clear;
    @(posedge clk) disable iff (!rst_b)
      (wrap && mode_r && act_r) |=> internal_reset_request && !ovf_r;
  endproperty
  a_rst_clear: assert property (p_rst_clear) else $error("reset action wrong");

  property p_no_clear_unarmed;
    @(posedge clk) disable iff (!rst_b)
      (ovf_r && !armed_r && wr_ctrl && writedata[EN_BIT] && !wrap) |=> ovf_r;
  endproperty
  a_no_clear_unarmed: assert property (p_no_clear_unarmed)
    else $error("flag cleared without read");

  property p_en_clear;
    @(posedge clk) disable iff (!rst_b)
      (wr_ctrl && !writedata[EN_BIT] && !wrap) |=> !ovf_r;
  endproperty
  a_en_clear: assert property (p_en_clear) else $error("flag kept after disable");

  property p_one_ignored;
    @(posedge clk) disable iff (!rst_b)
      (!ovf_r && !wrap) |=> !ovf_r;
  endproperty
  a_one_ignored: assert property (p_one_ignored) else $error("flag set without wrap");

  property p_nmi;
    @(posedge clk) disable iff (!rst_b)
      (wrap && mode_r && !act_r) |=> nmi_request && !internal_reset_request;
  endproperty
  a_nmi: assert property (p_nmi) else $error("nmi not requested");

  property p_itv;
    @(posedge clk) disable iff (!rst_b)
      (wrap && !mode_r) |=> interval_overflow_interrupt && ev_r[EV_ITV];
  endproperty
  a_itv: assert property (p_itv) else $error("interval interrupt missing");

  // status bit holds until software writes a one to it
  property p_sticky;
    @(posedge clk) disable iff (!rst_b)
      (ev_r[EV_ITV] && !(wr_st && writedata[EV_ITV])) |=> ev_r[EV_ITV];
  endproperty
  a_sticky: assert property (p_sticky) else $error("status bit lost");

  property p_step;
    @(posedge clk) disable iff (!rst_b)
      (en_r && tick && !wr_en) |=> count_r == $past(count_r) + 8'h01;
  endproperty
  a_step: assert property (p_step) else $error("counter did not step");

  // a clock-select write may move away from code 000 before the third cycle
  property p_div2;
    @(posedge clk) disable iff (!rst_b)
      (cks_r == 3'h0 && tick) |=> !tick ##1 (tick || cks_r != 3'h0);
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two wrong");

  // main scenarios reached
  c_itv: cover property (@(posedge clk) disable iff (!rst_b) interval_overflow_interrupt);
  c_wrap: cover property (@(posedge clk) disable iff (!rst_b) wrap);
  c_nmi: cover property (@(posedge clk) disable iff (!rst_b) nmi_request);
  c_rst: cover property (@(posedge clk) disable iff (!rst_b) internal_reset_request);
  c_arm_clear: cover property (@(posedge clk) disable iff (!rst_b) armed_r ##1 !ovf_r);

endmodule : watchdog_interval_timer_ch0

// >>> logic/wdt_pkg.sv
// ************************************************************
// watchdog channel 0 constants
// ************************************************************
package wdt_pkg;
  // ************************************************************
  // register byte addresses (word aligned)
  // ************************************************************
  localparam logic [3:0] ADDR_COUNT   = 4'h0;  // watchdog_count
  localparam logic [3:0] ADDR_CTRL    = 4'h4;  // watchdog_control_status
  localparam logic [3:0] ADDR_IRQ_ST  = 4'h8;  // sticky event status
  localparam logic [3:0] ADDR_IRQ_MSK = 4'hC;  // event mask
  // control/status field positions
  localparam int OVF_BIT  = 7;  // overflow_flag
  localparam int MODE_BIT = 6;  // timer_mode_select, 1 = watchdog
  localparam int EN_BIT   = 5;  // timer_enable_bit
  localparam int RSV_BIT  = 4;  // reserved, reads zero
  localparam int ACT_BIT  = 3;  // overflow action, 1 = internal reset
  // event status bit positions
  localparam int EV_ITV   = 0;  // interval overflow
  localparam int EV_NMI   = 1;  // nmi request
  localparam int EV_RST   = 2;  // internal reset request
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_MAX   = 8'hFF;
  // prescaler divisors per clock-select code
  localparam int DIV_000 = 2;
  localparam int DIV_001 = 32;
  localparam int DIV_010 = 128;
  localparam int DIV_011 = 512;
  localparam int DIV_100 = 2048;
  localparam int DIV_101 = 8192;
  localparam int DIV_110 = 32768;
  localparam int DIV_111 = 131072;
  localparam int PRE_W   = 17;  // prescaler width, covers 131072
  // bus answer states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } bus_state_e;
endpackage : wdt_pkg

// >>> testbench/testbench.sv
`timescale 1ns/1ns
// ************************************************************
// self-checking bench for watchdog channel 0
// ************************************************************
module testbench;
  import wdt_pkg::*;

  logic        clk         = 1'b0;   // 25 MHz system clock
  logic        rst_b       = 1'b0;   // async reset, active low
  logic [3:0]  address     = 4'h0;   // avalon byte address
  logic        read        = 1'b0;   // avalon read strobe
  logic        write       = 1'b0;   // avalon write strobe
  logic [31:0] writedata   = 32'h0;  // lane 0 carries the byte
  logic [3:0]  byteenable  = 4'hF;   // lane enables
  logic [31:0] readdata;             // answer data
  logic        waitrequest;          // low in the answer cycle
  logic        itv_p;                // interval overflow pulse
  logic        nmi_p;                // nmi request pulse
  logic        rst_p;                // internal reset pulse
  logic        irq;                  // level interrupt
  logic [31:0] rd;                   // last read value
  int          failures    = 0;      // mismatch count
  int          n_tests     = 0;      // comparison count
  int          n_itv       = 0;      // pulses seen, per output
  int          n_nmi       = 0;
  int          n_rst       = 0;

  // free-running clock, 40 ns period
  always #20 clk = ~clk;

  watchdog_interval_timer_ch0 watchdog_interval_timer_ch0_inst (
    .clk                         (clk),
    .rst_b                       (rst_b),
    .address                     (address),
    .read                        (read),
    .write                       (write),
    .writedata                   (writedata),
    .byteenable                  (byteenable),
    .readdata                    (readdata),
    .waitrequest                 (waitrequest),
    .interval_overflow_interrupt (itv_p),
    .nmi_request                 (nmi_p),
    .internal_reset_request      (rst_p),
    .irq                         (irq)
  );

  // pulses are one cycle wide, so the settled mid-cycle view counts each once
  always @(negedge clk) begin
    if (itv_p === 1'b1) n_itv++;
    if (nmi_p === 1'b1) n_nmi++;
    if (rst_p === 1'b1) n_rst++;
  end

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic give_verdict;
    $display("compares %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one avalon access; request held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                     input logic [3:0] be);
    int i;
    @(posedge clk);
    address    <= a;
    writedata  <= {24'h0, d};
    byteenable <= be;
    if (wr) write <= 1'b1;
    else read <= 1'b1;
    // values read just after an edge are the ones that edge sampled
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (waitrequest === 1'b0) break;
    end
    if (i == 50) begin
      failures++;
      give_verdict();
    end
    rd = readdata;
    write <= 1'b0;
    read  <= 1'b0;
    // return once the answer edge has settled, so callers see its effect
    @(negedge clk);
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    chk(rd, exp);
  endtask : rd_chk

  // bounded wait for any overflow pulse
  task automatic wait_ovf;
    int s;
    int i;
    s = n_itv + n_nmi + n_rst;
    for (i = 0; i < 2000; i++) begin
      @(posedge clk);
      if (n_itv + n_nmi + n_rst != s) break;
    end
    if (i == 2000) begin
      failures++;
      give_verdict();
    end
    repeat (2) @(posedge clk);
  endtask : wait_ovf

  // ************************************************************
  // scenarios
  // ************************************************************
  task automatic t_reset;
    rd_chk(ADDR_COUNT, 32'h0);
    rd_chk(ADDR_CTRL, 32'h0);
    rd_chk(ADDR_IRQ_ST, 32'h0);
    rd_chk(ADDR_IRQ_MSK, 32'h0);
    rd_chk(4'h2, 32'h0);                // unmapped place reads zero
    $display("test reset values done");
  endtask : t_reset

  task automatic t_rw;
    wr(ADDR_CTRL, 8'h27);               // slowest tick keeps the value still
    wr(ADDR_COUNT, 8'hA5);
    rd_chk(ADDR_COUNT, 32'hA5);
    bus(1'b1, ADDR_COUNT, 8'h11, 4'h0); // no lane enable, dropped
    rd_chk(ADDR_COUNT, 32'hA5);
    wr(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_COUNT, 32'h0);
    wr(ADDR_COUNT, 8'h5A);
    rd_chk(ADDR_COUNT, 32'h0);
    $display("test count access done");
  endtask : t_rw

  // counts over k cycles; prescaler phase allows a small window
  task automatic t_rate(input logic [2:0] code, input int div, input int k);
    wr(ADDR_CTRL, {5'b00100, code});
    wr(ADDR_COUNT, 8'h00);
    repeat (k) @(posedge clk);
    bus(1'b0, ADDR_COUNT, 8'h00, 4'hF);
    n_tests++;
    if (^rd === 1'bx || rd < 32'(k / div - 1) || rd > 32'(k / div + 2)) begin
      failures++;
      $display("MISMATCH at %0t: got %h expected %h", $time, rd, 32'(k / div));
    end
    wr(ADDR_CTRL, 8'h00);
    rd_chk(ADDR_COUNT, 32'h0);
    $display("test rate code %b done", code);
  endtask : t_rate

  task automatic t_interval;
    wr(ADDR_IRQ_MSK, 8'h00);
    wr(ADDR_CTRL, 8'h20);               // interval mode, fastest tick
    wr(ADDR_COUNT, 8'hFE);
    wait_ovf();
    chk(32'(n_itv), 32'h1);
    chk(32'(n_nmi + n_rst), 32'h0);
    chk({31'h0, irq}, 32'h0);           // masked event stays quiet
    wr(ADDR_IRQ_MSK, 8'h01);
    chk({31'h0, irq}, 32'h1);           // unmasked event drives irq
    rd_chk(ADDR_IRQ_ST, 32'h1);
    wr(ADDR_CTRL, 8'h24);               // zero without prior read; slow tick
    rd_chk(ADDR_CTRL, 32'hA4);
    wr(ADDR_CTRL, 8'h24);               // armed by the read above
    rd_chk(ADDR_CTRL, 32'h24);
    wr(ADDR_CTRL, 8'hA4);
    rd_chk(ADDR_CTRL, 32'h24);
    wr(ADDR_IRQ_ST, 8'h01);
    chk({31'h0, irq}, 32'h0);           // write-one-clear drops irq
    wr(ADDR_CTRL, 8'h20);
    wr(ADDR_COUNT, 8'hFE);
    wait_ovf();
    wr(ADDR_CTRL, 8'h00);               // no read first, so only disable clears
    rd_chk(ADDR_CTRL, 32'h0);
    wr(ADDR_IRQ_ST, 8'h07);
    wr(ADDR_IRQ_MSK, 8'h00);
    $display("test interval mode done");
  endtask : t_interval

  task automatic t_wd(input logic act);
    int s_itv;
    int s_nmi;
    int s_rst;
    s_itv = n_itv;
    s_nmi = n_nmi;
    s_rst = n_rst;
    wr(ADDR_CTRL, {4'b0110, act, 3'b000});
    wr(ADDR_COUNT, 8'hFE);
    wait_ovf();
    chk(32'(n_nmi - s_nmi), {31'h0, ~act});
    chk(32'(n_rst - s_rst), {31'h0, act});
    chk(32'(n_itv - s_itv), 32'h0);
    rd_chk(ADDR_CTRL, act ? 32'h68 : 32'hE0);
    rd_chk(ADDR_IRQ_ST, act ? 32'h4 : 32'h2);
    wr(ADDR_IRQ_ST, 8'h07);
    wr(ADDR_CTRL, 8'h00);
    $display("test watchdog action %b done", act);
  endtask : t_wd

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_rw();
    t_rate(3'b000, DIV_000, 200);
    t_rate(3'b001, DIV_001, 320);
    t_rate(3'b010, DIV_010, 1280);
    t_rate(3'b011, DIV_011, 2560);
    t_rate(3'b100, DIV_100, 4096);
    t_rate(3'b101, DIV_101, 16384);
    t_rate(3'b110, DIV_110, 32768);
    t_interval();
    t_wd(1'b0);
    t_wd(1'b1);
    give_verdict();
  end
endmodule : testbench
